// ---- core/tts_defines.vh ----
// Function
// - full mode always has exactly eight terms
// - trigger term selectable except term one
// - full mode triggers on entering trigger term
// - full simple trigger: term one, trigger two
// - easy mode: trigger on last-term primary branch
// - easy simple trigger: single term sequencer
// - easy primary branch goes to next term
// - full primary branch targets any term
// - easy shared secondary branch restarts term one
// - full per-term secondary condition and target
// - easy mode: one global storage qualifier
// - full mode: per-term storage qualifier
// - eight pattern comparators plus one range
// - pattern: and-equal, or-unequal, or constant
// - comparators writable only in full mode
// - two resource sets as grouped
// - intraset operator is OR or NOR
// - intraset first, then interset AND/OR
// - illegal qualifier refused with code 1249
// - easy mode holds at most four terms
`ifndef TTS_DEFINES_VH
`define TTS_DEFINES_VH
`define TTS_NTERMS 8
`define TTS_EASY_MAX 4
`define TTS_ERR_CODE 16'h04e1
`define TTS_ERR_NONE 16'h0000
`define TTS_TERM_ONE 3'h0
`define TTS_TERM_TWO 3'h1
`define TTS_PM_EQ_AND 3'h0
`define TTS_PM_NE_OR 3'h1
`define TTS_PM_ALL 3'h2
`define TTS_PM_ANY 3'h3
`define TTS_PM_NONE 3'h4
`define TTS_PM_NEVER 3'h5
`define TTS_Q_SEL1 0
`define TTS_Q_SEL2 7
`define TTS_Q_NOR1 13
`define TTS_Q_NOR2 14
`define TTS_Q_AND 15
`define TTS_Q_USE1 16
`define TTS_Q_USE2 17
`define TTS_Q_BAD 18
`define TTS_Q_W 19
`endif

// ---- core/tts_sequencer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "tts_defines.vh"
module tts_sequencer #(
  parameter DW = 32
) (
  input wire clock_i,
  input wire rstn_i,
  input wire init_i,
  input wire state_valid_i,
  input wire [DW-1:0] state_i,
  input wire arm_i,
  input wire full_mode_i,
  input wire simple_trigger_setup_i,
  input wire [`TTS_Q_W-1:0] simple_qual_i,
  input wire [2:0] easy_nterms_i,
  input wire [2:0] trig_term_i,
  input wire term_wr_i,
  input wire [2:0] term_idx_i,
  input wire [`TTS_Q_W-1:0] term_pri_qual_i,
  input wire [2:0] term_pri_dest_i,
  input wire [`TTS_Q_W-1:0] term_sec_qual_i,
  input wire [2:0] term_sec_dest_i,
  input wire [`TTS_Q_W-1:0] term_sto_qual_i,
  input wire sto_all_i,
  input wire [`TTS_Q_W-1:0] glob_sec_qual_i,
  input wire [`TTS_Q_W-1:0] glob_sto_qual_i,
  input wire pat_wr_i,
  input wire [2:0] pat_idx_i,
  input wire [2:0] pat_mode_i,
  input wire [DW-1:0] pat_value_i,
  input wire [DW-1:0] pat_mask_i,
  input wire rng_wr_i,
  input wire [DW-1:0] rng_lo_i,
  input wire [DW-1:0] rng_hi_i,
  output reg trigger_o,
  output reg triggered_o,
  output reg store_o,
  output reg [DW-1:0] store_data_o,
  output reg [2:0] term_o,
  output reg qual_err_o,
  output reg [15:0] err_code_o
);
  localparam NT = `TTS_NTERMS;
  reg [DW-1:0] st_s1_ff, st_s2_ff;
  reg vld_s1_ff, vld_s2_ff, arm_s1_ff, arm_s2_ff;
  reg [2:0] pmode_ff [0:NT-1];
  reg [DW-1:0] pval_ff [0:NT-1];
  reg [DW-1:0] pmsk_ff [0:NT-1];
  reg [DW-1:0] rlo_ff, rhi_ff;
  reg [`TTS_Q_W-1:0] pq_ff [0:NT-1];
  reg [`TTS_Q_W-1:0] sq_ff [0:NT-1];
  reg [`TTS_Q_W-1:0] oq_ff [0:NT-1];
  reg [2:0] pd_ff [0:NT-1];
  reg [2:0] sd_ff [0:NT-1];
  reg [2:0] trig_ff;
  reg [2:0] last_ff;
  reg [2:0] nxt_term;
  reg nxt_trig;
  reg [NT-1:0] pat_hit;
  reg in_rng;
  integer i;

  // pattern comparator match
  function pat_match;
    input [2:0] mode;
    input [DW-1:0] val, msk, s;
    begin
      case (mode)
        `TTS_PM_EQ_AND: pat_match = ((s ^ val) & msk) == {DW{1'b0}};
        `TTS_PM_NE_OR: pat_match = ((s ^ val) & msk) != {DW{1'b0}};
        `TTS_PM_ALL, `TTS_PM_ANY: pat_match = 1'b1;
        default: pat_match = 1'b0;
      endcase
    end
  endfunction

  // qualifier: sets grouped, intraset first, then interset
  function qual_eval;
    input [`TTS_Q_W-1:0] q;
    input [NT-1:0] p;
    input rin, arm;
    reg [5:0] m1;
    reg [4:0] m2;
    reg o1, o2, r1, r2;
    begin
      m1 = q[`TTS_Q_SEL1 +: 6];
      m2 = q[`TTS_Q_SEL2 +: 5];
      o1 = |(m1 & {~rin, rin, p[3:0]});
      o2 = |(m2 & {arm, p[7:4]});
      r1 = q[`TTS_Q_NOR1] ? ~o1 : o1;
      r2 = q[`TTS_Q_NOR2] ? ~o2 : o2;
      if (q[`TTS_Q_BAD])
        qual_eval = 1'b0;
      else if (q[`TTS_Q_USE1] && q[`TTS_Q_USE2])
        qual_eval = q[`TTS_Q_AND] ? (r1 & r2) : (r1 | r2);
      else if (q[`TTS_Q_USE1])
        qual_eval = r1;
      else if (q[`TTS_Q_USE2])
        qual_eval = r2;
      else
        qual_eval = 1'b0;
    end
  endfunction

  integer ip;
  integer it;
  integer io;
  reg nxt_store;
  reg bad_write;
  reg take_state;

  // two-flop synchroniser for the bus state word
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_s1_ff <= {DW{1'b0}};
      st_s2_ff <= {DW{1'b0}};
    end else begin
      st_s1_ff <= state_i;
      st_s2_ff <= st_s1_ff;
    end
  end

  // two-flop synchroniser for the state valid pin
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vld_s1_ff <= 1'b0;
      vld_s2_ff <= 1'b0;
    end else begin
      vld_s1_ff <= state_valid_i;
      vld_s2_ff <= vld_s1_ff;
    end
  end

  // two-flop synchroniser for the arm pin
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arm_s1_ff <= 1'b0;
      arm_s2_ff <= 1'b0;
    end else begin
      arm_s1_ff <= arm_i;
      arm_s2_ff <= arm_s1_ff;
    end
  end

  // comparators on the synchronised state
  always @* begin
    for (i = 0; i < NT; i = i + 1) begin
      pat_hit[i] = pat_match(pmode_ff[i], pval_ff[i], pmsk_ff[i],
        st_s2_ff);
    end
    in_rng = (st_s2_ff >= rlo_ff) && (st_s2_ff <= rhi_ff);
  end

  // next term and trigger
  always @* begin
    nxt_term = term_o;
    nxt_trig = 1'b0;
    if (full_mode_i) begin
      if (qual_eval(pq_ff[term_o], pat_hit, in_rng, arm_s2_ff)) begin
        nxt_term = pd_ff[term_o];
      end else if (qual_eval(sq_ff[term_o], pat_hit, in_rng, arm_s2_ff)) begin
        nxt_term = sd_ff[term_o];
      end
      if ((nxt_term == trig_ff) && (nxt_term != term_o)) begin
        nxt_trig = 1'b1;
      end
    end else begin
      if (qual_eval(pq_ff[term_o], pat_hit, in_rng, arm_s2_ff)) begin
        if (term_o == last_ff) begin
          nxt_trig = 1'b1;
          nxt_term = `TTS_TERM_ONE;
        end else begin
          nxt_term = term_o + 3'h1;
        end
      end else if (qual_eval(glob_sec_qual_i, pat_hit, in_rng, arm_s2_ff)) begin
        nxt_term = `TTS_TERM_ONE;
      end
    end
  end

  // storage decision for the state being evaluated
  always @* begin
    nxt_store = 1'b0;
    if (full_mode_i) begin
      nxt_store = qual_eval(oq_ff[term_o], pat_hit, in_rng, arm_s2_ff);
    end else begin
      nxt_store = qual_eval(glob_sto_qual_i, pat_hit, in_rng, arm_s2_ff);
    end
  end

  // a state is evaluated on every cycle the synchronised valid is high, until triggered
  always @* begin
    take_state = vld_s2_ff && !triggered_o;
  end

  // a term write carrying the illegal mark is refused whole
  always @* begin
    bad_write = term_pri_qual_i[`TTS_Q_BAD] | term_sec_qual_i[`TTS_Q_BAD] |
      term_sto_qual_i[`TTS_Q_BAD];
  end

  // pattern comparators, writable only in the full configuration
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (ip = 0; ip < NT; ip = ip + 1) begin
        pmode_ff[ip] <= `TTS_PM_NEVER;
        pval_ff[ip] <= {DW{1'b0}};
        pmsk_ff[ip] <= {DW{1'b0}};
      end
    end else if (pat_wr_i && full_mode_i) begin
      pmode_ff[pat_idx_i] <= pat_mode_i;
      pval_ff[pat_idx_i] <= pat_value_i;
      pmsk_ff[pat_idx_i] <= pat_mask_i;
    end
  end

  // range comparator bounds, inclusive
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rlo_ff <= {DW{1'b0}};
      rhi_ff <= {DW{1'b0}};
    end else if (rng_wr_i && full_mode_i) begin
      rlo_ff <= rng_lo_i;
      rhi_ff <= rng_hi_i;
    end
  end

  // trigger term of the full configuration; term one is never chosen
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_ff <= `TTS_TERM_TWO;
    end else if (simple_trigger_setup_i && full_mode_i) begin
      trig_ff <= `TTS_TERM_TWO;
    end else if (trig_term_i != `TTS_TERM_ONE) begin
      trig_ff <= trig_term_i;
    end
  end

  // last term of the easy configuration
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_ff <= `TTS_TERM_ONE;
    end else if (simple_trigger_setup_i && !full_mode_i) begin
      last_ff <= `TTS_TERM_ONE;
    end else if (easy_nterms_i != 3'h0 &&
        easy_nterms_i <= `TTS_EASY_MAX) begin
      last_ff <= easy_nterms_i - 3'h1;
    end
  end

  // branch tables: eight terms always present
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (it = 0; it < NT; it = it + 1) begin
        pq_ff[it] <= {`TTS_Q_W{1'b0}};
        sq_ff[it] <= {`TTS_Q_W{1'b0}};
        pd_ff[it] <= `TTS_TERM_ONE;
        sd_ff[it] <= `TTS_TERM_ONE;
      end
    end else begin
      if (term_wr_i && !bad_write) begin
        pq_ff[term_idx_i] <= term_pri_qual_i;
        pd_ff[term_idx_i] <= term_pri_dest_i;
        sq_ff[term_idx_i] <= term_sec_qual_i;
        sd_ff[term_idx_i] <= term_sec_dest_i;
      end
      if (simple_trigger_setup_i) begin
        pq_ff[0] <= simple_qual_i;
        pd_ff[0] <= `TTS_TERM_TWO;
      end
    end
  end

  // storage qualifiers, one per term or loaded into all at once
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (io = 0; io < NT; io = io + 1) begin
        oq_ff[io] <= {`TTS_Q_W{1'b0}};
      end
    end else if (term_wr_i && !bad_write) begin
      for (io = 0; io < NT; io = io + 1) begin
        if (sto_all_i || io == term_idx_i) begin
          oq_ff[io] <= term_sto_qual_i;
        end
      end
    end
  end

  // refusal of illegal qualifier combinations
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      qual_err_o <= 1'b0;
      err_code_o <= `TTS_ERR_NONE;
    end else if (term_wr_i) begin
      qual_err_o <= bad_write;
      if (bad_write) begin
        err_code_o <= `TTS_ERR_CODE;
      end else begin
        err_code_o <= `TTS_ERR_NONE;
      end
    end
  end

  // current sequence term
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      term_o <= `TTS_TERM_ONE;
    end else if (init_i) begin
      term_o <= `TTS_TERM_ONE;
    end else if (take_state) begin
      term_o <= nxt_term;
    end
  end

  // trigger pulse and the flag that holds until init
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trigger_o <= 1'b0;
      triggered_o <= 1'b0;
    end else if (init_i) begin
      trigger_o <= 1'b0;
      triggered_o <= 1'b0;
    end else if (take_state) begin
      trigger_o <= nxt_trig;
      triggered_o <= nxt_trig;
    end else begin
      trigger_o <= 1'b0;
    end
  end

  // storage strobe and captured state
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      store_o <= 1'b0;
      store_data_o <= {DW{1'b0}};
    end else if (init_i) begin
      store_o <= 1'b0;
    end else if (take_state) begin
      store_o <= nxt_store;
      store_data_o <= st_s2_ff;
    end else begin
      store_o <= 1'b0;
    end
  end
endmodule // tts_sequencer
`default_nettype wire

// ---- verif/tts_chk_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module tts_chk (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic init_i,
  input wire logic full_mode_i,
  input wire logic term_wr_i,
  input wire logic [18:0] term_pri_qual_i,
  input wire logic trigger_o,
  input wire logic triggered_o,
  input wire logic [2:0] term_o,
  input wire logic qual_err_o,
  input wire logic [15:0] err_code_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  trig_flag_a: assert property (trigger_o |-> triggered_o)
    else $error("flag missing");
  trig_pulse_a: assert property (trigger_o |=> !trigger_o)
    else $error("long trigger");
  flag_hold_a: assert property (
    triggered_o && !init_i |=> triggered_o)
    else $error("flag lost");
  init_clr_a: assert property (
    init_i |=> term_o == 3'h0 && !triggered_o)
    else $error("init failed");
  trig_term_a: assert property (
    full_mode_i && trigger_o |-> term_o != 3'h0)
    else $error("term one trigger");
  easy_wrap_a: assert property (
    !full_mode_i && trigger_o |-> term_o == 3'h0)
    else $error("no wrap");
  easy_step_a: assert property (
    !full_mode_i && $changed(term_o) &&
    term_o != 3'h0 |-> term_o == $past(term_o) + 3'h1)
    else $error("bad step");
  err_code_a: assert property (
    term_wr_i && term_pri_qual_i[18] |=>
    qual_err_o && err_code_o == 16'h04e1)
    else $error("not refused");
endmodule // tts_chk
`default_nettype wire

// ---- verif/tts_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tts_bus_model (
  input wire logic clock_i,
  output logic state_valid_o,
  output logic [7:0] state_o,
  output logic arm_o
);
  initial begin
    state_valid_o = 1'h0;
    state_o = 8'h00;
    arm_o = 1'h0;
  end
  // one bus state; released data shows the inverse
  // data settles a cycle before valid and stays a cycle after it
  task send(input logic [7:0] v);
    @(negedge clock_i);
    state_o = v;
    @(negedge clock_i);
    state_valid_o = 1'h1;
    @(negedge clock_i);
    state_valid_o = 1'h0;
    @(negedge clock_i);
    state_o = ~v;
    repeat (3) @(negedge clock_i);
  endtask
  task set_arm(input logic a);
    @(negedge clock_i);
    arm_o = a;
  endtask
endmodule // tts_bus_model
`default_nettype wire

// ---- verif/tts_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tts_sequencer_tb;
  logic clock_i = 0, rstn_i = 0, init_i = 0, full_mode_i = 0, arm_i;
  logic simple_trigger_setup_i = 0, term_wr_i = 0, sto_all_i = 0;
  logic pat_wr_i = 0, rng_wr_i = 0, state_valid_i;
  logic [7:0] state_i, pat_value_i = 0, pat_mask_i = 8'hff;
  logic [7:0] rng_lo_i = 8'h10, rng_hi_i = 8'h20;
  logic [2:0] easy_nterms_i = 1, trig_term_i = 1, term_idx_i = 0;
  logic [2:0] term_pri_dest_i = 0, term_sec_dest_i = 0;
  logic [2:0] pat_idx_i = 0, pat_mode_i = 0;
  logic [18:0] simple_qual_i = 0, term_pri_qual_i = 0;
  logic [18:0] term_sec_qual_i = 0, term_sto_qual_i = 0;
  logic [18:0] glob_sec_qual_i = 0, glob_sto_qual_i = 0;
  wire logic trigger_o, triggered_o, store_o, qual_err_o;
  wire logic [7:0] store_data_o;
  wire logic [2:0] term_o;
  wire logic [15:0] err_code_o;
  int miscompares = 0, compares = 0, ntrig = 0, nsto = 0;
  localparam logic [18:0] q_p1 = 19'h10001;
  localparam logic [18:0] q_np1 = 19'h12001;
  localparam logic [18:0] q_rng = 19'h10010;
  localparam logic [18:0] q_arm = 19'h20800;
  tts_sequencer #(.DW(8)) uut (.clock_i, .rstn_i, .init_i,
    .state_valid_i, .state_i, .arm_i, .full_mode_i,
    .simple_trigger_setup_i, .simple_qual_i, .easy_nterms_i,
    .trig_term_i, .term_wr_i, .term_idx_i, .term_pri_qual_i,
    .term_pri_dest_i, .term_sec_qual_i, .term_sec_dest_i,
    .term_sto_qual_i, .sto_all_i, .glob_sec_qual_i, .glob_sto_qual_i,
    .pat_wr_i, .pat_idx_i, .pat_mode_i, .pat_value_i, .pat_mask_i,
    .rng_wr_i, .rng_lo_i, .rng_hi_i, .trigger_o, .triggered_o,
    .store_o, .store_data_o, .term_o, .qual_err_o, .err_code_o);
  tts_bus_model bus (.clock_i, .state_valid_o(state_valid_i),
    .state_o(state_i), .arm_o(arm_i));
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    ntrig <= ntrig + (trigger_o === 1'h1);
    nsto <= nsto + (store_o === 1'h1);
  end
  task chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tw(input logic [2:0] i, input logic [18:0] p, s,
    input logic [2:0] pd, sd);
    {term_idx_i, term_pri_qual_i, term_sec_qual_i} = {i, p, s};
    {term_pri_dest_i, term_sec_dest_i, term_wr_i} = {pd, sd, 1'h1};
    @(negedge clock_i);
    term_wr_i = 0;
    @(negedge clock_i);
  endtask
  task pulse_init;
    init_i = 1;
    @(negedge clock_i);
    init_i = 0;
  endtask
  task final_report;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (16) @(negedge clock_i);
    rstn_i = 1;
    chk(term_o, 16'h0);
    {full_mode_i, pat_value_i, pat_wr_i, rng_wr_i} = {1'h1, 8'h5c, 2'h3};
    simple_qual_i = q_p1;
    simple_trigger_setup_i = 1;
    @(negedge clock_i);
    {pat_wr_i, rng_wr_i, simple_trigger_setup_i} = 3'h0;
    bus.send(8'h11);
    chk(term_o, 16'h0);
    bus.send(8'h5c);
    chk(term_o, 16'h1);
    chk(ntrig[15:0], 16'h1);
    pulse_init;
    chk(triggered_o, 16'h0);
    tw(0, q_p1 | 19'h40000, 0, 0, 0);
    chk(err_code_o, 16'h04e1);
    chk(qual_err_o, 16'h1);
    {term_sto_qual_i, sto_all_i, trig_term_i} = {q_p1, 1'h1, 3'h5};
    tw(0, q_p1, q_rng, 5, 3);
    chk(err_code_o, 16'h0);
    chk(qual_err_o, 16'h0);
    bus.send(8'h15);
    chk(term_o, 16'h3);
    pulse_init;
    bus.send(8'h5c);
    chk(term_o, 16'h5);
    chk({ntrig[3:0], nsto[3:0]}, 16'h21);
    chk(store_data_o, 16'h5c);
    {full_mode_i, pat_value_i, pat_wr_i} = {1'h0, 8'h11, 1'h1};
    {easy_nterms_i, pat_mode_i, pat_mask_i} = {3'h2, 3'h5, 8'h0f};
    {rng_wr_i, rng_lo_i, rng_hi_i} = {1'h1, 8'h30, 8'h40};
    @(negedge clock_i);
    {pat_wr_i, rng_wr_i, glob_sec_qual_i} = {2'h0, q_np1};
    glob_sto_qual_i = q_p1;
    pulse_init;
    tw(1, q_p1, 0, 0, 0);
    bus.send(8'h5c);
    chk(term_o, 16'h1);
    bus.send(8'h11);
    chk(term_o, 16'h0);
    bus.send(8'h5c);
    bus.send(8'h5c);
    chk(term_o, 16'h0);
    chk({ntrig[3:0], nsto[3:0]}, 16'h34);
    pulse_init;
    glob_sec_qual_i = q_arm;
    bus.send(8'h5c);
    chk(term_o, 16'h1);
    bus.set_arm(1'h1);
    bus.send(8'h11);
    chk(term_o, 16'h0);
    final_report;
  end
endmodule // tts_sequencer_tb
bind tts_sequencer tts_chk chk (.clock_i, .rstn_i, .init_i, .full_mode_i,
  .term_wr_i, .term_pri_qual_i, .trigger_o, .triggered_o, .term_o,
  .qual_err_o, .err_code_o);
`default_nettype wire
